// *** logic/awsw_regs.vh ***
// Purpose: constants for the task-file sector write command block
// Assumes: register index times four gives the apb byte address
// Notes:
// Contract
// - opcodes 30h and 31h write sectors; 3ch writes with verification.
// - legacy opcodes cdh and 38h run exactly as a plain sector write.
// - transfer length 1 to 256 sectors; zero means 256.
// - start at task-file address, advance one sector per sector written.
// - on accept set busy, then data request with busy cleared.
// - no interrupt when ready for the first buffer fill.
// - sector in buffer: busy, no request; next ready: request plus interrupt.
// - after last sector busy holds until done, then clear and interrupt.
// - on error stop at the failing sector, skip the rest.
// - on error leave failing sector address in the task-file registers.
// - unit/head: bits 7,5 one, bit 6 linear, bit 4 unit, 3:0 head.
// - linear mode: track high 23-16, track low 15-8, sector 7-0.
// - each sector is exactly 512 bytes of host data.
`ifndef AWSW_REGS_VH
`define AWSW_REGS_VH

// register indices; byte address is index times four
`define AWSW_IDX_DATA 4'h0
`define AWSW_IDX_PARAM 4'h1
`define AWSW_IDX_LEN 4'h2
`define AWSW_IDX_SECT 4'h3
`define AWSW_IDX_TRKL 4'h4
`define AWSW_IDX_TRKH 4'h5
`define AWSW_IDX_UNIT 4'h6
`define AWSW_IDX_OPC 4'h7
`define AWSW_IDX_IRQ 4'h8
`define AWSW_IDX_MASK 4'h9

`define AWSW_OP_WR0 8'h30
`define AWSW_OP_WR1 8'h31
`define AWSW_OP_VFY 8'h3c
`define AWSW_OP_LEG0 8'hcd
`define AWSW_OP_LEG1 8'h38

// sector is 128 words of 32 bits = 512 bytes
`define AWSW_LAST_WORD 7'h7f
`define AWSW_FULL_LEN 9'h100

`define AWSW_ST_BSY 7
`define AWSW_ST_DRDY 6
`define AWSW_ST_DRQ 3
`define AWSW_ST_ERR 0
`define AWSW_ER_ABRT 2
`define AWSW_ER_IDNF 4

`define AWSW_UH_LBA 6
`define AWSW_UH_RESET 8'ha0
`define AWSW_SECT_RESET 8'h01

`define AWSW_EV_DRQ 0
`define AWSW_EV_DONE 1
`define AWSW_EV_ERR 2

`endif

// *** logic/awsw_top.v ***
// Purpose: task-file sector write command engine with apb access
// Assumes: media side writes one buffered sector per request
// Notes: zero wait state apb slave, 32-bit data port
`timescale 1ns/10ps
`default_nettype none
`include "awsw_regs.vh"

module awsw_top #(
   parameter [7:0] SECT_PER_TRK = 8'h3f,
   parameter [3:0] HEAD_LAST = 4'hf
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg irq,
   output reg media_req,
   output reg media_verify,
   output reg [27:0] media_addr,
   output reg media_lba,
   input wire [6:0] media_rd_idx,
   output reg [31:0] media_rd_data,
   input wire media_done,
   input wire media_error
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ACCEPT = 3'h1;
   localparam [2:0] ST_FILL = 3'h2;
   localparam [2:0] ST_MEDIA = 3'h3;
   localparam [2:0] ST_WAIT = 3'h4;

   reg [31:0] buf_mem [0:127];
   reg [2:0] state_q;
   reg [7:0] len_q;
   reg [7:0] sect_q;
   reg [7:0] trkl_q;
   reg [7:0] trkh_q;
   reg [7:0] unit_q;
   reg [7:0] err_q;
   reg bsy_q;
   reg drq_q;
   reg errst_q;
   reg verify_q;
   reg [8:0] left_q;
   reg [6:0] widx_q;
   reg [2:0] irq_st_q;
   reg [2:0] mask_q;
   reg [2:0] irq_st_d;
   reg [2:0] mask_d;
   reg clr_irq;
   reg [2:0] ev;
   reg [7:0] stat;
   reg [31:0] rd_d;
   reg sect_wrap;
   reg head_wrap;

   wire setup = psel & ~penable;
   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire rd_acc = acc & ~pwrite;
   wire [3:0] idx = paddr[5:2];
   wire aligned = (paddr[1:0] == 2'h0) && (paddr[31:6] == 26'h000_0000);
   wire [7:0] wb = pwdata[7:0];
   wire lba_mode = unit_q[`AWSW_UH_LBA];

   // map opcode to write kind; 2'b01 plain, 2'b11 verify, 2'b00 unknown
   function [1:0] op_kind;
      input [7:0] op;
      begin
         case (op)
            `AWSW_OP_WR0, `AWSW_OP_WR1: op_kind = 2'b01;
            `AWSW_OP_LEG0, `AWSW_OP_LEG1: op_kind = 2'b01;
            `AWSW_OP_VFY: op_kind = 2'b11;
            default: op_kind = 2'b00;
         endcase
      end
   endfunction

   // register decode shared by read and write paths
   function mapped;
      input [3:0] i;
      begin
         mapped = (i <= `AWSW_IDX_MASK);
      end
   endfunction

   // one register hit by the access phase of a qualified transfer
   function hit;
      input strobe;
      input [3:0] i;
      input [3:0] want;
      begin
         hit = strobe & (i == want);
      end
   endfunction

   always @* begin
      stat = 8'h00;
      stat[`AWSW_ST_BSY] = bsy_q;
      stat[`AWSW_ST_DRDY] = ~bsy_q;
      stat[`AWSW_ST_DRQ] = drq_q;
      stat[`AWSW_ST_ERR] = errst_q;
   end

   always @* begin
      rd_d = 32'h0000_0000;
      case (idx)
         `AWSW_IDX_PARAM: rd_d[7:0] = err_q;
         `AWSW_IDX_LEN: rd_d[7:0] = len_q;
         `AWSW_IDX_SECT: rd_d[7:0] = sect_q;
         `AWSW_IDX_TRKL: rd_d[7:0] = trkl_q;
         `AWSW_IDX_TRKH: rd_d[7:0] = trkh_q;
         `AWSW_IDX_UNIT: rd_d[7:0] = unit_q;
         `AWSW_IDX_OPC: rd_d[7:0] = stat;
         // an event in the setup cycle must not be lost to the clear
         `AWSW_IDX_IRQ: rd_d[2:0] = irq_st_q | ev;
         `AWSW_IDX_MASK: rd_d[2:0] = mask_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // chs wrap points for the sequential advance
   always @* begin
      sect_wrap = (sect_q == SECT_PER_TRK);
      head_wrap = (unit_q[3:0] == HEAD_LAST);
   end

   // apb answer: pready registered, so every access has one wait-free beat
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~(aligned & mapped(idx));
         if (setup & ~pwrite & aligned) begin
            prdata <= rd_d;
         end else if (setup) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // sector buffer; only whole-word writes, strobes not honoured per lane
   always @(posedge pclk) begin
      if (wr & aligned & (idx == `AWSW_IDX_DATA) & (state_q == ST_FILL)) begin
         buf_mem[widx_q] <= pwdata;
      end
   end

   // read port cleared in reset like every other output
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         media_rd_data <= 32'h0000_0000;
      end else begin
         media_rd_data <= buf_mem[media_rd_idx];
      end
   end

   always @* begin
      ev = 3'b000;
      if ((state_q == ST_WAIT) & media_done) begin
         if (media_error) begin
            ev[`AWSW_EV_ERR] = 1'b1;
            ev[`AWSW_EV_DONE] = 1'b1;
         end else if (left_q == 9'h001) begin
            ev[`AWSW_EV_DONE] = 1'b1;
         end else begin
            ev[`AWSW_EV_DRQ] = 1'b1;
         end
      end
      if (wr & aligned & (idx == `AWSW_IDX_OPC) & (state_q == ST_IDLE) &
          (op_kind(wb) == 2'b00)) begin
         ev[`AWSW_EV_ERR] = 1'b1;
         ev[`AWSW_EV_DONE] = 1'b1;
      end
   end

   // next sticky and mask values; a new event wins over the read that clears
   always @* begin
      clr_irq = hit(rd_acc & aligned, idx, `AWSW_IDX_IRQ);
      if (clr_irq) begin
         irq_st_d = ev;
      end else begin
         irq_st_d = irq_st_q | ev;
      end
      mask_d = mask_q;
      if (hit(wr & aligned, idx, `AWSW_IDX_MASK) & pstrb[0]) begin
         mask_d = pwdata[2:0];
      end
   end

   // irq follows the next values so a mask write takes effect at once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_q <= 3'b000;
         mask_q <= 3'b000;
         irq <= 1'b0;
      end else begin
         irq_st_q <= irq_st_d;
         mask_q <= mask_d;
         irq <= |(irq_st_d & mask_d);
      end
   end

   // command sequencer and task file
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         len_q <= 8'h01;
         sect_q <= `AWSW_SECT_RESET;
         trkl_q <= 8'h00;
         trkh_q <= 8'h00;
         unit_q <= `AWSW_UH_RESET;
         err_q <= 8'h00;
         bsy_q <= 1'b0;
         drq_q <= 1'b0;
         errst_q <= 1'b0;
         verify_q <= 1'b0;
         left_q <= 9'h000;
         widx_q <= 7'h00;
         media_req <= 1'b0;
         media_verify <= 1'b0;
         media_addr <= 28'h000_0000;
         media_lba <= 1'b0;
      end else begin
         media_req <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (wr & aligned) begin
                  case (idx)
                     `AWSW_IDX_LEN: len_q <= wb;
                     `AWSW_IDX_SECT: sect_q <= wb;
                     `AWSW_IDX_TRKL: trkl_q <= wb;
                     `AWSW_IDX_TRKH: trkh_q <= wb;
                     `AWSW_IDX_UNIT: unit_q <= wb;
                     `AWSW_IDX_OPC: begin
                        err_q <= 8'h00;
                        if (op_kind(wb) == 2'b00) begin
                           err_q[`AWSW_ER_ABRT] <= 1'b1;
                           errst_q <= 1'b1;
                        end else begin
                           // param register deliberately not consulted
                           verify_q <= op_kind(wb) == 2'b11;
                           errst_q <= 1'b0;
                           bsy_q <= 1'b1;
                           state_q <= ST_ACCEPT;
                           if (len_q == 8'h00) begin
                              left_q <= `AWSW_FULL_LEN;
                           end else begin
                              left_q <= {1'b0, len_q};
                           end
                        end
                     end
                     default: err_q <= err_q;
                  endcase
               end
            end
            ST_ACCEPT: begin
               // first fill raises no event
               bsy_q <= 1'b0;
               drq_q <= 1'b1;
               widx_q <= 7'h00;
               state_q <= ST_FILL;
            end
            ST_FILL: begin
               if (wr & aligned & (idx == `AWSW_IDX_DATA)) begin
                  widx_q <= widx_q + 7'h01;
                  if (widx_q == `AWSW_LAST_WORD) begin
                     bsy_q <= 1'b1;
                     drq_q <= 1'b0;
                     state_q <= ST_MEDIA;
                  end
               end
            end
            ST_MEDIA: begin
               media_req <= 1'b1;
               media_verify <= verify_q;
               media_lba <= lba_mode;
               // both addressing modes share one field packing
               if (lba_mode) begin
                  media_addr <= {unit_q[3:0], trkh_q, trkl_q, sect_q};
               end else begin
                  media_addr <= {unit_q[3:0], trkh_q, trkl_q, sect_q};
               end
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (media_done) begin
                  if (media_error) begin
                     // task file still names the failing sector
                     err_q[`AWSW_ER_IDNF] <= 1'b1;
                     errst_q <= 1'b1;
                     bsy_q <= 1'b0;
                     state_q <= ST_IDLE;
                  end else begin
                     left_q <= left_q - 9'h001;
                     len_q <= len_q - 8'h01;
                     if (lba_mode) begin
                        {unit_q[3:0], trkh_q, trkl_q, sect_q} <=
                           {unit_q[3:0], trkh_q, trkl_q, sect_q} +
                           28'h000_0001;
                     end else if (!sect_wrap) begin
                        sect_q <= sect_q + 8'h01;
                     end else begin
                        sect_q <= `AWSW_SECT_RESET;
                        if (!head_wrap) begin
                           unit_q[3:0] <= unit_q[3:0] + 4'h1;
                        end else begin
                           unit_q[3:0] <= 4'h0;
                           {trkh_q, trkl_q} <= {trkh_q, trkl_q} + 16'h0001;
                        end
                     end
                     if (left_q == 9'h001) begin
                        bsy_q <= 1'b0;
                        state_q <= ST_IDLE;
                     end else begin
                        bsy_q <= 1'b0;
                        drq_q <= 1'b1;
                        widx_q <= 7'h00;
                        state_q <= ST_FILL;
                     end
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               bsy_q <= 1'b0;
               drq_q <= 1'b0;
            end
         endcase
      end
   end

endmodule // awsw_top
`default_nettype wire

// *** verification/awsw_checker.sv ***
// Purpose: port checks for the sector write engine
// Assumes: zero wait apb slave
// Notes: bound onto awsw_top
`timescale 1ns/10ps
`default_nettype none
module awsw_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic media_req,
   input wire logic media_verify,
   input wire logic media_lba,
   input wire logic [27:0] media_addr
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_unmapped_err: assert property (psel && !penable && paddr[5:2] > 4'h9
      |=> pslverr) else $error("unmapped without slverr");
   a_mapped_ok: assert property (psel && !penable && paddr[5:2] <= 4'h9
      && paddr[1:0] == 2'b00 && paddr[31:6] == 26'h000_0000 |=> !pslverr)
      else $error("slverr on mapped");
   a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data on write");
   a_req_spacing: assert property (media_req |=> !media_req [*8])
      else $error("sector request too soon");
   a_cmd_stable: assert property (media_req |=> $stable(media_verify)
      && $stable(media_lba)) else $error("mode moved");
   a_addr_hold: assert property (media_req |=> $stable(media_addr))
      else $error("address moved at request");
endmodule // awsw_checker
bind awsw_top awsw_checker awsw_checker_i (.*);
`default_nettype wire

// *** verification/awsw_media_model.sv ***
// Purpose: media side, drains and commits one sector
// Assumes: buffer word one cycle after its index
// Notes: fail_next makes the commit report an error
`timescale 1ns/10ps
`default_nettype none
module awsw_media_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic media_req,
   input wire logic [31:0] media_rd_data,
   input wire logic fail_next,
   input wire logic [3:0] wait_cyc,
   output logic [6:0] media_rd_idx,
   output logic media_done,
   output logic media_error,
   output logic [31:0] sum
);
   logic [8:0] cnt_q;
   logic busy_q;
   assign media_rd_idx = cnt_q[6:0];
   // error only means something with done, so it wanders
   assign media_error = media_done ? fail_next : cnt_q[0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 9'h000;
         busy_q <= 1'b0;
         media_done <= 1'b0;
         sum <= 32'h0;
      end else begin
         media_done <= 1'b0;
         cnt_q <= cnt_q + 9'h001;
         if (media_req) begin
            busy_q <= 1'b1;
            cnt_q <= 9'h000;
            sum <= 32'h0;
         end else if (busy_q && cnt_q == 9'h081 + {5'h0, wait_cyc}) begin
            busy_q <= 1'b0;
            media_done <= 1'b1;
         end else if (busy_q && cnt_q != 9'h000 && cnt_q < 9'h081) begin
            sum <= sum + media_rd_data;
         end
      end
   end
endmodule // awsw_media_model
`default_nettype wire

// *** verification/test_awsw_top.sv ***
// Purpose: self-checking bench for the sector write engine
// Assumes: media model on the far side
// Notes: short counts keep the run brief
`timescale 1ns/10ps
`default_nettype none
`include "awsw_regs.vh"
module test_awsw_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, irq, media_req, media_verify, media_lba, se;
   logic media_done, media_error, fail_next = 0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, media_rd_data, sum, r;
   logic [27:0] media_addr, req_addr;
   logic [6:0] media_rd_idx;
   logic [3:0] pstrb = 4'hf, wait_cyc = 4'h0;
   int miscompares = 0, check_count = 0;
   awsw_top awsw_top_i (.*);
   awsw_media_model awsw_media_model_i (.*);
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (media_req) req_addr <= media_addr;
   task chk(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [3:0] ix, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {26'h0, ix, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rd(input logic [3:0] ix, input logic [31:0] e);
      apb(1'b0, ix, 32'h0);
      chk(r, e);
   endtask
   task poll(input logic [7:0] e);
      int n;
      n = 0;
      do begin
         apb(1'b0, 4'h7, 32'h0);
         n++;
      end while ((r[7:0] & 8'h89) !== e && n < 300);
      chk(r[7:0] & 8'h89, e);
   endtask
   task fill(input logic [31:0] b);
      for (int i = 0; i < 128; i++) apb(1'b1, 4'h0, b + i);
   endtask
   task go(input logic [31:0] n, s, u, op);
      apb(1'b1, 4'h2, n);
      apb(1'b1, 4'h3, s);
      apb(1'b1, 4'h4, 8'h34);
      apb(1'b1, 4'h5, 8'h12);
      apb(1'b1, 4'h6, u);
      apb(1'b1, 4'h1, ~op);
      apb(1'b1, 4'h7, op);
      poll(8'h08);
   endtask
   task t_reset;
      rd(4'h3, `AWSW_SECT_RESET);
      rd(4'h6, `AWSW_UH_RESET);
      rd(4'h7, 8'h40);
      apb(1'b1, 4'h9, 8'h07);
      rd(4'h9, 8'h07);
      apb(1'b0, 4'ha, 32'h0);
      chk(se, 1'b1);
   endtask
   task t_ops;
      logic [7:0] op [5];
      op = '{`AWSW_OP_WR0, `AWSW_OP_WR1, `AWSW_OP_VFY, 8'hcd, 8'h38};
      foreach (op[i]) begin
         go(8'h01, 8'h05, 8'ha0, op[i]);
         chk(irq, 1'b0);
         rd(4'h8, 8'h00);
         fill(i << 8);
         poll(8'h00);
         chk(sum, (i << 15) + 32'h0000_1fc0);
         chk(media_verify, op[i] == `AWSW_OP_VFY);
         chk(req_addr, 28'h012_3405);
         chk(irq, 1'b1);
         rd(4'h8, 8'h02);
      end
   endtask
   task t_lba;
      wait_cyc <= 4'hf;
      go(8'h02, 8'hff, 8'he5, `AWSW_OP_WR0);
      fill(32'h0000_0100);
      poll(8'h80);
      poll(8'h08);
      chk(irq, 1'b1);
      rd(4'h8, 8'h01);
      chk(req_addr, 28'h512_34ff);
      fill(32'h0000_0200);
      poll(8'h00);
      rd(4'h8, 8'h02);
      chk(req_addr, 28'h512_3500);
      chk(media_lba, 1'b1);
      wait_cyc <= 4'h0;
   endtask
   task t_err;
      go(8'h00, 8'h05, 8'ha0, `AWSW_OP_VFY);
      fill(32'h0);
      poll(8'h08);
      rd(4'h8, 8'h01);
      rd(4'h2, 8'hff);
      fail_next <= 1'b1;
      fill(32'h0);
      poll(8'h01);
      fail_next <= 1'b0;
      rd(4'h3, 8'h06);
      rd(4'h2, 8'hff);
      rd(4'h1, 8'h10);
      rd(4'h8, 8'h06);
      chk(req_addr, 28'h012_3406);
   endtask
   task t_badop;
      apb(1'b1, 4'h9, 8'h00);
      apb(1'b1, 4'h7, 8'hee);
      poll(8'h01);
      rd(4'h1, 8'h04);
      chk(irq, 1'b0);
      apb(1'b1, 4'h9, 8'h07);
      @(posedge pclk);
      chk(irq, 1'b1);
      rd(4'h8, 8'h06);
      @(posedge pclk);
      chk(irq, 1'b0);
   endtask
   task close_out;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ops();
      t_lba();
      t_err();
      t_badop();
      close_out();
   end
   // a hung handshake must still end the run
   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      close_out();
   end
endmodule // test_awsw_top
`default_nettype wire
